//--- cthr_map.svh
/*
  register map, field layout and reset values of the cpu throttle control
  block. assumes 32-bit apb data, one aligned word per register.
*/
`ifndef CTHR_MAP_SVH
`define CTHR_MAP_SVH

`define CTHR_CTRL_ADDR 12'h000
`define CTHR_STAT_ADDR 12'h004
`define CTHR_CTRL_RST 32'h0000_0000
`define CTHR_RD_RST 32'h0000_0000
`define CTHR_EN_BIT 0
`define CTHR_ROI_BIT 1
`define CTHR_DOE_BIT 2
`define CTHR_RATIO_LSB 4
`define CTHR_RATIO_MSB 6
`define CTHR_STAT_PHASE_LSB 8
`define CTHR_CNT_W 8
`define CTHR_CNT_ZERO 8'h00
`define CTHR_CNT_ONE 8'h01

`endif

//--- cthr_pkg.sv
/*
  types shared by the cpu throttle control block.
  assumes cthr_map.svh is on the include path.
*/
package cthr_pkg;
  typedef logic [2:0] cthr_ratio_t;
  typedef logic [31:0] cthr_word_t;
  typedef logic [11:0] cthr_addr_t;
  typedef enum logic [1:0] {
    CTHR_FULL = 2'b00,
    CTHR_THROTTLED = 2'b01
  } cthr_mode_t;
endpackage

//--- cthr_top.sv
/*
  cpu throttle control: gates cpu and program memory cycles while the
  peripheral instruction clock keeps running.
  assumes one system clock, an apb master, and a cpu sequencer that
  pulses irq and return-from-interrupt strobes on the same clock.
*/
// Behaviour
// - enabled: one active cycle per N
// - ratio code 100 gives 1:32
// - ratio code 001 gives 1:4
// - peripherals stay at full speed
// - oscillators never stopped by throttling
// - prefetch runs ahead of each phase-zero active cycle, and with a recover grant
// - peripheral instruction clock runs without gaps
// - irq without recover keeps throttled rate
// - irq with recover clears enable, full speed
// - return with rethrottle sets enable again
`timescale 1ns/1ns
`default_nettype none
`include "cthr_map.svh"

module cthr_top (
  // clock and reset
  input wire logic CLOCK_IN,
  input wire logic SRST_IN,
  // apb slave
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire cthr_pkg::cthr_addr_t PADDR_IN,
  input wire cthr_pkg::cthr_word_t PWDATA_IN,
  input wire logic [3:0] PSTRB_IN,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  output cthr_pkg::cthr_word_t PRDATA_OUT,
  // cpu sequencer events
  input wire logic IRQ_IN,
  input wire logic RETURN_FROM_INTERRUPT_IN,
  // cycle enables
  output logic CPU_CYCLE_EN_OUT,
  output logic PREFETCH_EN_OUT,
  output logic PERIPH_CYCLE_EN_OUT,
  output logic OSC_RUN_OUT
);
  import cthr_pkg::*;

  logic throttle_enable_r;
  logic throttle_enable_nxt;
  logic recover_on_irq_r;
  logic rethrottle_on_return_r;
  cthr_ratio_t ratio_r;
  logic [`CTHR_CNT_W-1:0] phase_r;
  logic [`CTHR_CNT_W-1:0] phase_nxt;
  cthr_word_t prdata_r;
  logic pslverr_r;
  cthr_word_t ctrl_rst_w;
  cthr_word_t ctrl_word;
  cthr_word_t stat_word;
  cthr_word_t rd_word;
  logic cpu_en;
  logic fetch_en;

  // idle cycles after each active one: 2^(code+1) - 1
  function automatic logic [`CTHR_CNT_W-1:0] idle_count(cthr_ratio_t code);
    logic [`CTHR_CNT_W:0] n;
    logic [3:0] amt;
    // four-bit shift count: code 7 must reach 2^8, not wrap to 2^0
    amt = {1'b0, code} + 4'h1;
    n = 9'(`CTHR_CNT_ONE) << amt;
    idle_count = n[`CTHR_CNT_W-1:0] - `CTHR_CNT_ONE;
  endfunction

  // readback word of the control register
  function automatic cthr_word_t pack_ctrl(logic en, logic recover_on_irq, logic rethrottle_on_return,
                                           cthr_ratio_t code);
    cthr_word_t w;
    w = `CTHR_RD_RST;
    w[`CTHR_EN_BIT] = en;
    w[`CTHR_ROI_BIT] = recover_on_irq;
    w[`CTHR_DOE_BIT] = rethrottle_on_return;
    w[`CTHR_RATIO_MSB:`CTHR_RATIO_LSB] = code;
    pack_ctrl = w;
  endfunction

  // readback word of the status register
  function automatic cthr_word_t pack_stat(logic en,
                                           logic [`CTHR_CNT_W-1:0] phase);
    cthr_word_t w;
    w = `CTHR_RD_RST;
    w[`CTHR_EN_BIT] = en;
    w[`CTHR_STAT_PHASE_LSB +: `CTHR_CNT_W] = phase;
    pack_stat = w;
  endfunction

  wire access = PSEL_IN & PENABLE_IN;
  wire hit_ctrl = (PADDR_IN == `CTHR_CTRL_ADDR);
  wire hit_stat = (PADDR_IN == `CTHR_STAT_ADDR);
  wire wr_ctrl = access & PWRITE_IN & hit_ctrl & PSTRB_IN[0];
  wire unmapped = ~(hit_ctrl | hit_stat);
  wire setup = PSEL_IN & ~PENABLE_IN;
  assign ctrl_rst_w = `CTHR_CTRL_RST;
  wire [`CTHR_CNT_W-1:0] last_phase = idle_count(ratio_r);
  wire at_active = (phase_r == `CTHR_CNT_ZERO);
  wire recover = IRQ_IN & recover_on_irq_r & throttle_enable_r;
  wire rethrottle = RETURN_FROM_INTERRUPT_IN & rethrottle_on_return_r;
  cthr_mode_t mode;
  assign mode = throttle_enable_r ? CTHR_THROTTLED : CTHR_FULL;

  // hardware events win over a same-cycle software write
  always_comb begin
    throttle_enable_nxt = throttle_enable_r;
    if (wr_ctrl) begin
      throttle_enable_nxt = PWDATA_IN[`CTHR_EN_BIT];
    end
    if (recover) begin
      throttle_enable_nxt = 1'b0;
    end else if (rethrottle) begin
      throttle_enable_nxt = 1'b1;
    end
  end

  // phase restarts at the active slot; irq without recover keeps counting
  always_comb begin
    if (mode == CTHR_FULL || phase_r >= last_phase) begin
      phase_nxt = `CTHR_CNT_ZERO;
    end else begin
      phase_nxt = phase_r + `CTHR_CNT_ONE;
    end
  end

  // enable: hardware events are already folded into the next value
  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      throttle_enable_r <= ctrl_rst_w[`CTHR_EN_BIT];
    end else begin
      throttle_enable_r <= throttle_enable_nxt;
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      recover_on_irq_r <= ctrl_rst_w[`CTHR_ROI_BIT];
    end else if (wr_ctrl) begin
      recover_on_irq_r <= PWDATA_IN[`CTHR_ROI_BIT];
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      rethrottle_on_return_r <= ctrl_rst_w[`CTHR_DOE_BIT];
    end else if (wr_ctrl) begin
      rethrottle_on_return_r <= PWDATA_IN[`CTHR_DOE_BIT];
    end
  end

  // ratio changes take effect from the next phase compare
  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      ratio_r <= ctrl_rst_w[`CTHR_RATIO_MSB:`CTHR_RATIO_LSB];
    end else if (wr_ctrl) begin
      ratio_r <= PWDATA_IN[`CTHR_RATIO_MSB:`CTHR_RATIO_LSB];
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      phase_r <= `CTHR_CNT_ZERO;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  // read data registered at the setup phase
  assign ctrl_word = pack_ctrl(throttle_enable_r, recover_on_irq_r,
                               rethrottle_on_return_r, ratio_r);
  assign stat_word = pack_stat(throttle_enable_r, phase_r);

  always_comb begin
    if (hit_ctrl) begin
      rd_word = ctrl_word;
    end else if (hit_stat) begin
      rd_word = stat_word;
    end else begin
      rd_word = `CTHR_RD_RST;
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      prdata_r <= `CTHR_RD_RST;
    end else if (setup) begin
      prdata_r <= rd_word;
    end
  end

  // error flag lives for the access phase only
  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      pslverr_r <= 1'b0;
    end else begin
      pslverr_r <= setup & unmapped;
    end
  end

  assign PREADY_OUT = 1'b1;
  assign PSLVERR_OUT = pslverr_r & access;
  assign PRDATA_OUT = prdata_r;

  // cpu runs every cycle at full speed, else only on the active slot;
  // a recovering irq grants the slot at once, no wait for phase zero
  always_comb begin
    case (mode)
      CTHR_THROTTLED: begin
        cpu_en = at_active | recover;
        fetch_en = recover | (phase_r == last_phase);
      end
      default: begin
        cpu_en = 1'b1;
        fetch_en = 1'b1;
      end
    endcase
  end

  assign CPU_CYCLE_EN_OUT = cpu_en;
  // fetch for a phase-zero slot happens in the slot before it; a recovering irq fetches in its own cycle
  assign PREFETCH_EN_OUT = fetch_en;
  assign PERIPH_CYCLE_EN_OUT = ~SRST_IN | 1'b1;
  assign OSC_RUN_OUT = 1'b1;
endmodule
`default_nettype wire

//--- cthr_monitor.sv
/* checker on cthr_top ports; assumes software writes only ctrl. */
`timescale 1ns/1ns
`default_nettype none
module cthr_monitor (
  // clock, reset, apb
  input wire logic CLOCK_IN,
  input wire logic SRST_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire cthr_pkg::cthr_word_t PWDATA_IN,
  // events and enables
  input wire logic IRQ_IN,
  input wire logic RETURN_FROM_INTERRUPT_IN,
  input wire logic CPU_CYCLE_EN_OUT,
  input wire logic PREFETCH_EN_OUT,
  input wire logic PERIPH_CYCLE_EN_OUT,
  input wire logic OSC_RUN_OUT
);
  import cthr_pkg::*;
  logic [6:0] c_r;
  logic [7:0] idle_r;
  wire logic en = c_r[0];
  // code 7 gives 9'h100 - 1 = 9'h0ff in nine bits, cut to 8'hff, which is what we want
  wire logic [7:0] gap = 8'((9'h002 << c_r[6:4]) - 9'h001);
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (SRST_IN);
  // enable mirror; hardware events beat software
  always_ff @(posedge CLOCK_IN) begin
    idle_r <= CPU_CYCLE_EN_OUT ? 8'h00 : idle_r + 8'h01;
    if (SRST_IN) c_r <= 7'h00;
    else if (IRQ_IN && en && c_r[1]) c_r[0] <= 1'b0;
    else if (RETURN_FROM_INTERRUPT_IN && c_r[2]) c_r[0] <= 1'b1;
    else if (PSEL_IN && PENABLE_IN && PWRITE_IN) c_r <= PWDATA_IN[6:0];
  end
  a_off_full: assert property (!en |-> CPU_CYCLE_EN_OUT)
    else $error("cpu gated while off");
  a_ratio_gap: assert property (en && $rose(CPU_CYCLE_EN_OUT) && !IRQ_IN
    |-> idle_r == gap) else $error("idle run wrong");
  a_irq_slow: assert property (en && !c_r[1] && IRQ_IN
    && idle_r + 8'h01 < gap |=> !CPU_CYCLE_EN_OUT) else $error("irq sped up");
  a_recover_fast: assert property (en && c_r[1] && IRQ_IN
    |-> CPU_CYCLE_EN_OUT [*2]) else $error("no recovery");
  a_rethrottle: assert property (!en && c_r[2] && RETURN_FROM_INTERRUPT_IN
    |=> CPU_CYCLE_EN_OUT ##1 !CPU_CYCLE_EN_OUT) else $error("no rethrottle");
  a_prefetch: assert property (en && $rose(CPU_CYCLE_EN_OUT) && !IRQ_IN
    |-> $past(PREFETCH_EN_OUT)) else $error("slot without prefetch");
  a_periph_run: assert property (PERIPH_CYCLE_EN_OUT)
    else $error("peripheral gap");
  a_osc_run: assert property (OSC_RUN_OUT)
    else $error("oscillator stopped");
endmodule
bind cthr_top cthr_monitor mon_u (.*);
`default_nettype wire

//--- cthr_cpu_model.sv
/* cpu sequencer stand-in: tallies granted cycles; same clock. */
`timescale 1ns/1ns
`default_nettype none
module cthr_cpu_model (
  // clock, reset, gate
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic run_in,
  // tally
  output logic [15:0] runs_out
);
  always_ff @(posedge clk_in) begin
    if (rst_in) runs_out <= 16'h0000;
    else if (run_in) runs_out <= runs_out + 16'h0001;
  end
endmodule
`default_nettype wire

//--- cthr_tb.sv
/* throttle bench; assumes cthr_top, cthr_cpu_model, apb slave. */
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import cthr_pkg::*;
  logic clk = 1'b0, rst = 1'b1, sel = 1'b0, ena = 1'b0, wr = 1'b0;
  logic irq = 1'b0, ret = 1'b0, rdy, err, e, cpu;
  cthr_addr_t adr = 12'h000;
  cthr_word_t wd = 32'h0, prd, rd;
  logic [15:0] runs, c0;
  // code in bits 14:12, active cycles seen in a 256-cycle window
  logic [15:0] rows [8] = '{16'h0081, 16'h1041, 16'h2021, 16'h3011,
    16'h4009, 16'h5005, 16'h6003, 16'h7002};
  int bad_count = 0, n_compared = 0;
  always #25 clk = ~clk;
  cthr_top dut_u (.CLOCK_IN(clk), .SRST_IN(rst), .PSEL_IN(sel),
    .PENABLE_IN(ena), .PWRITE_IN(wr), .PADDR_IN(adr), .PWDATA_IN(wd),
    .PSTRB_IN(4'hf), .PREADY_OUT(rdy), .PSLVERR_OUT(err), .PRDATA_OUT(prd),
    .IRQ_IN(irq), .RETURN_FROM_INTERRUPT_IN(ret), .CPU_CYCLE_EN_OUT(cpu),
    .PREFETCH_EN_OUT(), .PERIPH_CYCLE_EN_OUT(), .OSC_RUN_OUT());
  cthr_cpu_model cpu_u (.clk_in(clk), .rst_in(rst), .run_in(cpu),
    .runs_out(runs));
  task automatic chk(string s, cthr_word_t x, cthr_word_t g);
    n_compared++;
    if (g !== x) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", s, x, g);
    end
  endtask
  task automatic apb(logic w, cthr_addr_t a, cthr_word_t d);
    logic done;
    @(posedge clk);
    {sel, wr, adr, wd} <= {1'b1, w, a, d};
    @(posedge clk);
    ena <= 1'b1;
    // answer sampled at the falling edge; loop ends once rdy reads 1, else the watchdog ends it
    do begin
      @(negedge clk);
      done = rdy;
      {rd, e} = {prd, err};
      @(posedge clk);
    end while (done !== 1'b1);
    {sel, ena} <= 2'b00;
  endtask
  task automatic stat(cthr_word_t x);
    apb(1'b0, 12'h004, 32'h0);
    chk("status enable", x, {31'h0, rd[0]});
  endtask
  task end_of_test;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    end_of_test;
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, 12'h000, 32'h0);
    chk("ctrl reset", 32'h0, rd);
    apb(1'b0, 12'h008, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, e});
    $display("reset test done");
    foreach (rows[i]) begin
      apb(1'b1, 12'h000, {25'h0, rows[i][14:12], 4'h1});
      c0 = runs;
      repeat (256) @(posedge clk);
      chk("active", {20'h0, rows[i][11:0]}, {16'h0, runs - c0});
      apb(1'b1, 12'h000, 32'h0);
    end
    $display("ratio test done");
    apb(1'b1, 12'h000, 32'h11);
    irq <= 1'b1;
    repeat (4) @(posedge clk);
    irq <= 1'b0;
    stat(32'h1);
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b1, 12'h000, 32'h27);
    irq <= 1'b1;
    @(posedge clk);
    irq <= 1'b0;
    stat(32'h0);
    ret <= 1'b1;
    @(posedge clk);
    ret <= 1'b0;
    stat(32'h1);
    $display("event test done");
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, 12'h000, 32'h0);
    chk("ctrl after midrun reset", 32'h0, rd);
    $display("midrun reset test done");
    end_of_test;
  end
endmodule
`default_nettype wire
